// ===== core/atc_map.svh
// Register offsets, field positions, reset values and counts of the converter trigger block.
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH

// ==========================================================================
// Register offsets
`define ATC_OFS_TRIG_CTL   8'hE1
`define ATC_OFS_CMP_CTL    8'hE2
`define ATC_OFS_DLY_LO     8'hE3
`define ATC_OFS_STATUS     8'hE8
`define ATC_OFS_THR_LO     8'hF0
`define ATC_OFS_THR_HI     8'hF1
`define ATC_OFS_RES_LO     8'hF2
`define ATC_OFS_RES_HI     8'hF3
`define ATC_OFS_PWM_RUN    8'hF4

// ==========================================================================
// Field positions
`define ATC_TC_PIN_SEL     6
`define ATC_TC_DIV_HI      5
`define ATC_TC_DIV_LO      4
`define ATC_TC_TYPE_HI     3
`define ATC_TC_TYPE_LO     2
`define ATC_TC_EXT_EN      1
`define ATC_TC_CONV_EN     0
`define ATC_CC_BRAKE_EN    7
`define ATC_CC_POL         6
`define ATC_CC_GATE_EN     5
`define ATC_CC_CMP_OUT     4
`define ATC_CC_ACQ_HI      3
`define ATC_CC_ACQ_LO      1
`define ATC_CC_DLY8        0
`define ATC_ST_DONE        7
`define ATC_ST_START       6
`define ATC_ST_SRC_HI      5
`define ATC_ST_SRC_LO      4

// ==========================================================================
// Reset values and counts
`define ATC_RST_BYTE       8'h00
`define ATC_TC_WMASK       8'h7F
`define ATC_ACQ_TABLE      64'h1E1A16120E0A0602

`endif

// ===== core/atc_pkg.sv
// Types shared by the converter trigger and compare block.
package atc_pkg;

  // Gray-coded sequencer states along idle, delay, acquire, convert.
  typedef enum logic [1:0]
  {
    ATC_IDLE  = 2'h0,
    ATC_DELAY = 2'h1,
    ATC_ACQ   = 2'h3,
    ATC_CONV  = 2'h2
  } atc_state_e;

  // Whole state of the block, registered in one place.
  typedef struct packed
  {
    atc_state_e  st;
    logic [7:0]  trig_ctl;
    logic [7:0]  cmp_ctl;
    logic [7:0]  dly_lo;
    logic [11:0] thr;
    logic [11:0] result;
    logic [1:0]  trig_src;
    logic        busy;
    logic        done;
    logic [2:0]  presc;
    logic        tick;
    logic [8:0]  dly_cnt;
    logic [7:0]  acq_cnt;
    logic [1:0]  pin_a_sync;
    logic [1:0]  pin_b_sync;
    logic        trig_prev;
    logic        conv_start;
    logic        brake;
    logic        pwm_run;
    logic [7:0]  rdata;
  } atc_state_s;

endpackage

// ===== core/atc_top.sv
// Converter trigger routing, clock division, sequencing and result compare control.
`timescale 1ns/1ns
`include "atc_map.svh"

module atc_top
  import atc_pkg::*;
#(
  parameter logic [63:0] ACQ_TABLE = `ATC_ACQ_TABLE
)
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // External start pins, asynchronous
  input  wire logic        START_PIN_A,
  input  wire logic        START_PIN_B,
  // PWM generator, same clock
  input  wire logic        PWM_CH0,
  input  wire logic        PWM_CH2,
  input  wire logic        PWM_CH4,
  input  wire logic        PWM_CENTER,
  input  wire logic        PWM_END,
  input  wire logic        PWM_CENTER_ALIGNED,
  output logic             PWM_RUN,
  output logic             FAULT_BRAKE,
  // Converter core
  output logic             CONV_POWER,
  output logic             CONV_CLK_TICK,
  output logic             CONV_START,
  input  wire logic        CONV_DONE,
  input  wire logic [11:0] CONV_RESULT,
  // Status toward the interrupt controller
  output logic             DONE_FLAG,
  output logic             BUSY
);

  atc_state_s q;
  atc_state_s d;

  // ==========================================================================
  // Decoded fields and events

  logic [1:0]  div;
  logic [1:0]  ttype;
  logic        ext_en;
  logic        pin_lvl;
  logic        trig_lvl;
  logic        ext_evt;
  logic        ext_fire;
  logic        sw_start;
  logic        can_start;
  logic [2:0]  div_mask;
  logic [8:0]  dly_total;
  logic [7:0]  acq_len;
  logic        cmp_now;
  logic        conv_end;
  logic        wr_status;

  // Field slices and the selected trigger level.
  always_comb
  begin
    div       = q.trig_ctl[`ATC_TC_DIV_HI:`ATC_TC_DIV_LO];
    ttype     = q.trig_ctl[`ATC_TC_TYPE_HI:`ATC_TC_TYPE_LO];
    ext_en    = q.trig_ctl[`ATC_TC_EXT_EN];
    // The pin mux reads the live select bit, so a write switches pins at once.
    pin_lvl   = q.trig_ctl[`ATC_TC_PIN_SEL] ? q.pin_b_sync[1] : q.pin_a_sync[1];
    unique case (q.trig_src)
      2'h0:    trig_lvl = PWM_CH0;
      2'h1:    trig_lvl = PWM_CH2;
      2'h2:    trig_lvl = PWM_CH4;
      2'h3:    trig_lvl = pin_lvl;
    endcase
    // Centre and end events exist only in centre-aligned counting.
    unique case (ttype)
      2'h0:    ext_evt = q.trig_prev & ~trig_lvl;
      2'h1:    ext_evt = ~q.trig_prev & trig_lvl;
      2'h2:    ext_evt = PWM_CENTER & PWM_CENTER_ALIGNED;
      2'h3:    ext_evt = PWM_END & PWM_CENTER_ALIGNED;
    endcase
    wr_status = WR && (ADDR == `ATC_OFS_STATUS);
    sw_start  = wr_status && WDATA[`ATC_ST_START];
    // A raised done flag or a running conversion refuses new starts.
    can_start = (q.st == ATC_IDLE) && !q.done;
    ext_fire  = can_start && ext_en && ext_evt && !sw_start;
    div_mask  = 3'((4'h1 << div) - 4'h1);
    dly_total = {q.cmp_ctl[`ATC_CC_DLY8], q.dly_lo};
    acq_len   = ACQ_TABLE[8 * q.cmp_ctl[`ATC_CC_ACQ_HI:`ATC_CC_ACQ_LO] +: 8];
    // Comparison against the incoming result, with the polarity in force now.
    cmp_now   = q.cmp_ctl[`ATC_CC_POL] ? (CONV_RESULT < q.thr)
                                       : (CONV_RESULT >= q.thr);
    conv_end  = (q.st == ATC_CONV) && CONV_DONE;
  end

  // ==========================================================================
  // Next-state logic

  always_comb
  begin
    d            = q;
    d.conv_start = 1'b0;
    d.rdata      = `ATC_RST_BYTE;

    // Start pins pass two flip-flops before anything reads them.
    d.pin_a_sync = {q.pin_a_sync[0], START_PIN_A};
    d.pin_b_sync = {q.pin_b_sync[0], START_PIN_B};
    d.trig_prev  = trig_lvl;

    // Converter clock as a one-cycle tick every 1, 2, 4 or 8 system clocks.
    d.tick  = (q.presc & div_mask) == div_mask;
    d.presc = q.presc + 3'h1;

    // Register writes.
    if (WR)
    begin
      unique case (ADDR)
        `ATC_OFS_TRIG_CTL: d.trig_ctl = WDATA & `ATC_TC_WMASK;
        `ATC_OFS_CMP_CTL:  d.cmp_ctl  = {WDATA[7:5], q.cmp_ctl[`ATC_CC_CMP_OUT], WDATA[3:0]};
        `ATC_OFS_DLY_LO:   d.dly_lo   = WDATA;
        `ATC_OFS_THR_LO:   d.thr      = {q.thr[11:8], WDATA};
        `ATC_OFS_THR_HI:   d.thr      = {WDATA[3:0], q.thr[7:0]};
        `ATC_OFS_PWM_RUN:  d.pwm_run  = WDATA[0];
        `ATC_OFS_STATUS:
        begin
          d.done     = WDATA[`ATC_ST_DONE];
          d.trig_src = WDATA[`ATC_ST_SRC_HI:`ATC_ST_SRC_LO];
        end
        default:           d.rdata    = `ATC_RST_BYTE;
      endcase
    end

    // Software sets run again to leave the brake.
    if (WR && (ADDR == `ATC_OFS_PWM_RUN) && WDATA[0])
    begin
      d.brake = 1'b0;
    end

    // Sequencer.
    unique case (q.st)
      ATC_IDLE:
      begin
        if (can_start && sw_start)
        begin
          // Software start skips the trigger delay.
          d.st      = ATC_ACQ;
          d.busy    = 1'b1;
          d.acq_cnt = acq_len;
        end
        else if (ext_fire)
        begin
          d.busy    = 1'b1;
          d.dly_cnt = dly_total;
          d.acq_cnt = acq_len;
          d.st      = (dly_total == 9'h000) ? ATC_ACQ : ATC_DELAY;
        end
      end
      ATC_DELAY:
      begin
        // Delay is counted in converter clock ticks.
        if (q.tick)
        begin
          d.dly_cnt = q.dly_cnt - 9'h001;
          if (q.dly_cnt == 9'h001)
          begin
            d.st = ATC_ACQ;
          end
        end
      end
      ATC_ACQ:
      begin
        // Acquisition window before the core is told to convert.
        if (q.acq_cnt == 8'h00)
        begin
          d.st         = ATC_CONV;
          d.conv_start = 1'b1;
        end
        else if (q.tick)
        begin
          d.acq_cnt = q.acq_cnt - 8'h01;
        end
      end
      ATC_CONV:
      begin
        if (CONV_DONE)
        begin
          d.result                  = CONV_RESULT;
          d.cmp_ctl[`ATC_CC_CMP_OUT] = cmp_now;
          if (q.cmp_ctl[`ATC_CC_GATE_EN] && !cmp_now)
          begin
            // Gated mode keeps converting until the result matches.
            d.st      = ATC_ACQ;
            d.acq_cnt = acq_len;
          end
          else
          begin
            d.st   = ATC_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
          end
        end
      end
    endcase

    // Brake and run clear beat a software write in the same cycle.
    if (conv_end && cmp_now && q.cmp_ctl[`ATC_CC_BRAKE_EN])
    begin
      d.brake   = 1'b1;
      d.pwm_run = 1'b0;
    end

    // Read data, valid in the cycle after the strobe.
    if (RD)
    begin
      unique case (ADDR)
        `ATC_OFS_TRIG_CTL: d.rdata = q.trig_ctl;
        `ATC_OFS_CMP_CTL:  d.rdata = q.cmp_ctl;
        `ATC_OFS_DLY_LO:   d.rdata = q.dly_lo;
        `ATC_OFS_THR_LO:   d.rdata = q.thr[7:0];
        `ATC_OFS_THR_HI:   d.rdata = {4'h0, q.thr[11:8]};
        `ATC_OFS_RES_LO:   d.rdata = q.result[7:0];
        `ATC_OFS_RES_HI:   d.rdata = {4'h0, q.result[11:8]};
        `ATC_OFS_PWM_RUN:  d.rdata = {7'h00, q.pwm_run};
        `ATC_OFS_STATUS:   d.rdata = {q.done, q.busy, q.trig_src, 4'h0};
        default:           d.rdata = `ATC_RST_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // State register

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign RDATA         = q.rdata;
  assign PWM_RUN       = q.pwm_run;
  assign FAULT_BRAKE   = q.brake;
  assign CONV_POWER    = q.trig_ctl[`ATC_TC_CONV_EN];
  assign CONV_CLK_TICK = q.tick;
  assign CONV_START    = q.conv_start;
  assign DONE_FLAG     = q.done;
  assign BUSY          = q.busy;

  // ==========================================================================
  // Checks

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  sequence seq_fire_delayed;
    ext_fire && (dly_total > 9'h001);
  endsequence

  sequence seq_waiting;
    (q.st == ATC_DELAY) [*2];
  endsequence

  chk_delay_wait: assert property (seq_fire_delayed |=> seq_waiting)
    else $error("External trigger did not wait for its delay.");

  // A tick made under an older divider setting does not open the count.
  chk_div_eight: assert property (
    q.tick && (div == 2'h3) && ($past(div) == 2'h3) |=> (!q.tick || (div != 2'h3)) [*7])
    else $error("Divide by eight tick came early.");

  chk_ext_off_ignored: assert property (
    (q.st == ATC_IDLE) && !ext_en && !(WR && (ADDR == `ATC_OFS_STATUS))
    |=> (q.st == ATC_IDLE))
    else $error("Conversion began without a software start.");

  chk_centre_gated: assert property (
    (q.st == ATC_IDLE) && !PWM_CENTER_ALIGNED && ttype[1] && !sw_start
    |=> (q.st == ATC_IDLE))
    else $error("Centre or end trigger fired in edge-aligned mode.");

  chk_busy_shown: assert property ((q.st != ATC_IDLE) |-> q.busy)
    else $error("Busy low while a conversion runs.");

  chk_done_blocks: assert property (
    q.done && (q.st == ATC_IDLE) |=> (q.st == ATC_IDLE))
    else $error("Conversion began while done flag was set.");

  chk_cmp_polarity: assert property (
    conv_end |=> (q.cmp_ctl[`ATC_CC_CMP_OUT] == ($past(q.cmp_ctl[`ATC_CC_POL])
      ? ($past(CONV_RESULT) < $past(q.thr)) : ($past(CONV_RESULT) >= $past(q.thr)))))
    else $error("Comparator bit disagrees with polarity.");

  chk_gate_done: assert property (
    $rose(q.done) && q.cmp_ctl[`ATC_CC_GATE_EN] |-> q.cmp_ctl[`ATC_CC_CMP_OUT])
    else $error("Gated done flag set without compare match.");

  chk_gate_repeat: assert property (
    conv_end && q.cmp_ctl[`ATC_CC_GATE_EN] && !cmp_now |=> (q.st == ATC_ACQ) && !q.done)
    else $error("Gated mode stopped before a match.");

  chk_brake_run: assert property (
    conv_end && cmp_now && q.cmp_ctl[`ATC_CC_BRAKE_EN] |=> q.brake && !q.pwm_run)
    else $error("Brake did not assert or run stayed set.");

  // ==========================================================================
  // Sequencer and register checks

  // Named steps of a conversion, from the end of acquisition to the start pulse.
  sequence seq_acq_over;
    (q.st == ATC_ACQ) && (q.acq_cnt == 8'h00);
  endsequence

  sequence seq_conv_begun;
    q.conv_start && (q.st == ATC_CONV);
  endsequence

  // The core is told to convert in the cycle after the acquisition count runs out.
  chk_acq_then_start: assert property (seq_acq_over |=> seq_conv_begun)
    else $error("Start pulse did not follow acquisition.");

  // A software start taken while idle shows busy at once and skips the delay.
  chk_sw_start_taken: assert property (
    can_start && sw_start |=> q.busy && (q.st == ATC_ACQ))
    else $error("Software start was not taken.");

  // Every accepted external event loads the whole nine-bit delay count.
  chk_delay_loaded: assert property (
    ext_fire |=> q.busy && (q.dly_cnt == $past(dly_total)))
    else $error("Trigger delay count was not loaded.");

  // Events that arrive during a conversion leave it running.
  chk_busy_ignores: assert property (
    (q.st == ATC_CONV) && ext_evt && !CONV_DONE |=> (q.st == ATC_CONV))
    else $error("Trigger disturbed a running conversion.");

  // A completion that ends the run raises done and drops busy together.
  chk_done_raised: assert property (
    conv_end && (!q.cmp_ctl[`ATC_CC_GATE_EN] || cmp_now)
    |=> q.done && !q.busy && (q.st == ATC_IDLE))
    else $error("Done flag or busy wrong after a completion.");

  // The result only moves on an accepted completion, so software reads a whole value.
  chk_result_held: assert property (
    !conv_end |=> (q.result == $past(q.result)))
    else $error("Result changed without a completion.");

  // Divide by one ticks every cycle; the first cycle out of reset still shows zero.
  chk_div_one: assert property (
    $past(RSTN) && (div == 2'h0) && ($past(div) == 2'h0) |-> q.tick)
    else $error("Divide by one missed a tick.");

  // A status write picks the trigger origin for the next event.
  chk_src_written: assert property (
    WR && (ADDR == `ATC_OFS_STATUS)
    |=> (q.trig_src == $past(WDATA[`ATC_ST_SRC_HI:`ATC_ST_SRC_LO])))
    else $error("Trigger source was not taken from the write.");

  // Setting run by software releases the brake unless a new match wins the cycle.
  chk_run_restart: assert property (
    WR && (ADDR == `ATC_OFS_PWM_RUN) && WDATA[0]
    && !(conv_end && cmp_now && q.cmp_ctl[`ATC_CC_BRAKE_EN]) |=> q.pwm_run && !q.brake)
    else $error("Run bit set did not release the brake.");

endmodule

// ===== tb/atc_core_model.sv
// Behavioural converter core that answers start pulses with a result.
`timescale 1ns/1ns

module atc_core_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Converter handshake
  input  wire logic        conv_start,
  output logic             conv_done,
  output logic      [11:0] conv_result,
  // Bench controls
  input  wire logic [11:0] sample_value,
  input  wire logic [7:0]  latency
);
  logic [7:0]  wait_cnt;
  logic        running;
  logic [11:0] last_value;

  // ==========================================================================
  // Conversion timing
  // Outside the done cycle the bus shows the inverse of the last value, so a
  // design that samples the result late cannot pass by luck.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      running     <= 1'b0;
      wait_cnt    <= 8'h00;
      conv_done   <= 1'b0;
      last_value  <= 12'h000;
      conv_result <= 12'hFFF;
    end
    else
    begin
      conv_done   <= 1'b0;
      conv_result <= ~last_value;
      if (conv_start)
      begin
        running  <= 1'b1;
        wait_cnt <= latency;
      end
      else if (running && wait_cnt == 8'h00)
      begin
        running     <= 1'b0;
        conv_done   <= 1'b1;
        conv_result <= sample_value;
        last_value  <= sample_value;
      end
      else if (running)
      begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the converter trigger and compare block.
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end

module tb;
  logic        CLK_SYS = 0, RSTN = 0, WR = 0, RD = 0, START_PIN_A = 0, START_PIN_B = 0;
  logic        PWM_CH0 = 0, PWM_CH2 = 0, PWM_CH4 = 0, PWM_CENTER = 0, PWM_END = 0;
  logic        PWM_CENTER_ALIGNED = 0, PWM_RUN, FAULT_BRAKE, CONV_POWER, CONV_CLK_TICK;
  logic        CONV_START, CONV_DONE, DONE_FLAG, BUSY, hit, sel, pol;
  logic [7:0]  ADDR = 0, WDATA = 0, RDATA, rv, w, latency = 8'h03;
  logic [11:0] CONV_RESULT, sample_value = 0, thr, val;
  logic [1:0]  src_now = 0;
  int          num_errors = 0, comparisons = 0, n, n0, n1, cnt;

  atc_top atc_top_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .START_PIN_A(START_PIN_A), .START_PIN_B(START_PIN_B),
    .PWM_CH0(PWM_CH0), .PWM_CH2(PWM_CH2), .PWM_CH4(PWM_CH4), .PWM_CENTER(PWM_CENTER),
    .PWM_END(PWM_END), .PWM_CENTER_ALIGNED(PWM_CENTER_ALIGNED), .PWM_RUN(PWM_RUN),
    .FAULT_BRAKE(FAULT_BRAKE), .CONV_POWER(CONV_POWER), .CONV_CLK_TICK(CONV_CLK_TICK),
    .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
    .DONE_FLAG(DONE_FLAG), .BUSY(BUSY));
  atc_core_model atc_core_model_inst (.clk(CLK_SYS), .rst_n(RSTN), .conv_start(CONV_START),
    .conv_done(CONV_DONE), .conv_result(CONV_RESULT), .sample_value(sample_value),
    .latency(latency));

  // 25 MHz system clock.
  always #20 CLK_SYS = ~CLK_SYS;

  // ==========================================================================
  // Expectations and bus tasks
  function automatic logic cmp_exp(input logic [11:0] v, input logic [11:0] t, input logic p);
    return p ? (v < t) : (v >= t);
  endfunction

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    WR    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample at its end.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    @(posedge CLK_SYS);
    d = RDATA;
  endtask

  // Bounded wait for a start pulse or the done flag; running out fails the run.
  task automatic wait_hi(input logic want_done, output int k);
    k = 0;
    do
    begin
      @(posedge CLK_SYS);
      k++;
      if (k > 3000)
      begin
        num_errors++;
        tally_and_finish();
      end
    end
    while ((want_done ? DONE_FLAG : CONV_START) !== 1'b1);
  endtask

  task automatic finish_conv();
    wait_hi(1'b1, n);
    wr(8'hE8, {2'b00, src_now, 4'h0});
  endtask

  task automatic watch_busy();
    hit = 1'b0;
    repeat (10)
    begin
      @(posedge CLK_SYS);
      hit = hit | BUSY;
    end
  endtask

  // One trigger event on the chosen source; edge sources simply toggle.
  task automatic fire(input int s, input int t, input logic p);
    @(posedge CLK_SYS);
    if (t == 2) PWM_CENTER <= 1'b1;
    else if (t == 3) PWM_END <= 1'b1;
    else if (s == 0) PWM_CH0 <= ~PWM_CH0;
    else if (s == 1) PWM_CH2 <= ~PWM_CH2;
    else if (s == 2) PWM_CH4 <= ~PWM_CH4;
    else if (p) START_PIN_B <= ~START_PIN_B;
    else START_PIN_A <= ~START_PIN_A;
    @(posedge CLK_SYS);
    PWM_CENTER <= 1'b0;
    PWM_END    <= 1'b0;
  endtask

  // Cycles from a start request to the start pulse at the converter.
  task automatic meas(input logic [7:0] cc, input logic ext, output int k);
    wr(8'hE2, cc);
    if (ext) fire(0, 1, 1'b0);
    else wr(8'hE8, 8'h40);
    wait_hi(1'b0, k);
    PWM_CH0 <= 1'b0;
    finish_conv();
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h91B5));
    repeat (10) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    rd(8'hE1, rv);
    `CHK(rv, 8'h00)
    rd(8'hE2, rv);
    `CHK(rv, 8'h00)
    w = $urandom;
    wr(8'hE1, w);
    wr(8'h10, 8'hFF);
    rd(8'hE1, rv);
    `CHK(rv, w & 8'h7F)
    rd(8'h10, rv);
    `CHK(rv, 8'h00)
    w = $urandom;
    wr(8'hE2, w);
    rd(8'hE2, rv);
    `CHK(rv, w & 8'hEF)
    wr(8'hE2, 8'h00);
    // Divider ratio: tick count over a window of sixteen system cycles. The tick
    // seen at the first edge was made under the old setting, so that edge is skipped.
    for (int d = 0; d < 4; d++)
    begin
      wr(8'hE1, {2'b00, d[1:0], 3'b000, d[0]});
      @(posedge CLK_SYS);
      cnt = 0;
      repeat (16)
      begin
        @(posedge CLK_SYS);
        cnt += int'(CONV_CLK_TICK);
      end
      `CHK(cnt, 16 >> d)
      `CHK(CONV_POWER, d[0])
    end
    // Every source and edge type, off and on, with wrong-pin events too; the start
    // pin is run once on each of its two alternatives.
    for (int s = 0; s < 4; s++)
      for (int t = 0; t < 2; t++)
      begin
        sel = (s == 3) ? t[0] : 1'($urandom);
        wr(8'hE1, 8'h00);
        {PWM_CH0, PWM_CH2, PWM_CH4, START_PIN_A, START_PIN_B} <= {5{t == 0}};
        src_now = s[1:0];
        wr(8'hE8, {2'b00, src_now, 4'h0});
        wr(8'hE1, {1'b0, sel, 2'b00, t[1:0], 2'b00});
        fire(s, t, sel);
        watch_busy();
        `CHK(hit, 1'b0)
        fire(s, t, sel);
        wr(8'hE1, {1'b0, sel, 2'b00, t[1:0], 2'b10});
        if (s == 3) fire(s, t, ~sel);
        watch_busy();
        `CHK(hit, 1'b0)
        fire(s, t, sel);
        watch_busy();
        `CHK(hit, 1'b1)
        finish_conv();
      end
    // Delay only on external starts; acquisition length from the table.
    {PWM_CH0, PWM_CH2, PWM_CH4, START_PIN_A, START_PIN_B} <= 5'h00;
    src_now = 2'b00;
    wr(8'hE8, 8'h00);
    wr(8'hE1, 8'h06);
    wr(8'hE3, 8'h01);
    meas(8'h00, 1'b1, n0);
    meas(8'h01, 1'b1, n1);
    `CHK(n1 - n0, 256)
    meas(8'h00, 1'b0, n0);
    meas(8'h0F, 1'b0, n1);
    `CHK(n1 - n0, 28)
    // Random results against random thresholds, both polarities.
    for (int i = 0; i < 6; i++)
    begin
      thr = $urandom;
      val = (i < 2) ? thr - i[11:0] : 12'($urandom);
      pol = i[0];
      latency <= 8'($urandom_range(0, 20));
      sample_value <= val;
      wr(8'hF0, thr[7:0]);
      wr(8'hF1, {4'h0, thr[11:8]});
      wr(8'hE2, {1'b0, pol, 6'h00});
      wr(8'hE8, 8'h40);
      rd(8'hE8, rv);
      `CHK(rv[6], 1'b1)
      wait_hi(1'b1, n);
      `CHK(BUSY, 1'b0)
      rd(8'hE2, rv);
      `CHK(rv[4], cmp_exp(val, thr, pol))
      rd(8'hF2, rv);
      `CHK(rv, val[7:0])
      rd(8'hF3, rv);
      `CHK(rv, {4'h0, val[11:8]})
      wr(8'hE8, 8'hC0);
      watch_busy();
      `CHK(hit, 1'b0)
      wr(8'hE8, 8'h00);
    end
    // Gated repeats until a match, which then brakes the PWM.
    wr(8'hF4, 8'h01);
    wr(8'hF0, 8'h00);
    wr(8'hF1, 8'h08);
    sample_value <= 12'h100;
    wr(8'hE2, 8'hA0);
    wr(8'hE8, 8'h40);
    repeat (3) wait_hi(1'b0, n);
    `CHK({BUSY, DONE_FLAG, FAULT_BRAKE}, 3'b100)
    sample_value <= 12'hF00;
    wait_hi(1'b1, n);
    @(posedge CLK_SYS);
    `CHK({FAULT_BRAKE, PWM_RUN}, 2'b10)
    wr(8'hF4, 8'h01);
    @(posedge CLK_SYS);
    `CHK({FAULT_BRAKE, PWM_RUN}, 2'b01)
    wr(8'hE8, 8'h00);
    // Period-point triggers need centre alignment; repeats while busy are lost.
    latency <= 8'h28;
    for (int t = 2; t < 4; t++)
    begin
      PWM_CENTER_ALIGNED <= 1'b0;
      wr(8'hE1, {4'h0, t[1:0], 2'b10});
      fire(0, t, 1'b0);
      watch_busy();
      `CHK(hit, 1'b0)
      PWM_CENTER_ALIGNED <= 1'b1;
      fire(0, t, 1'b0);
      watch_busy();
      `CHK(hit, 1'b1)
      fire(0, t, 1'b0);
      finish_conv();
      watch_busy();
      `CHK(hit, 1'b0)
    end
    tally_and_finish();
  end
endmodule
